// [verilog/stl_top.sv]
// threshold monitor and telegram scheduler, temperature and humidity
// assumes same-clock measurement and bus-receive logic, AXI4-Lite master
//
// What this block does
// - humidity threshold of channel two is held within 20 to 90 percent.
// - humidity hysteresis choices are none, 10, 15 or 20 percent.
// - rising modes set chosen level above threshold, clear below threshold minus hysteresis.
// - falling modes set chosen level below threshold, clear above threshold plus hysteresis.
// - variants silence one crossing while the other still sends on or off.
// - a silenced condition also silences cyclic limit telegrams while it holds.
// - threshold comes from config, a received 16-bit or 8-bit value.
// - change to one is accepted after the switch-on delay, none to 60 min.
// - change to zero is accepted after the switch-off delay, none to 60 min.
// - during a delay the old limit value keeps being sent, also cyclically.
// - send-on-change off sends no change telegram, cyclic sending still runs.
// - send-on-change on sends the limit value on every toggle.
// - limit telegrams repeat every cycle setting times ten seconds, zero disables.
// - no change sending and zero cycle means the limit is never sent.
// - temperature limits may be none, channel one, or channels one and two.
// - temperature is sent on a step of 0.5, 1, 3 or 10 percent of 60 degrees.
// - a change-triggered temperature telegram waits a fixed ten seconds.
// - temperature is sent every setting times ten seconds, zero sends nothing cyclic.
// - cyclic measurement sending runs independently of change-triggered sending.
// - temperature threshold of channel one is held within -15 to +50 degrees.
// - temperature hysteresis is none, 1 to 5, 10, 15 or 20 kelvin.
// - humidity channel two exists only with humidity on and both limits chosen.
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "stl_consts.svh"
module stl_top #(
    parameter int unsigned TICK_CYCLES = `STL_CLK_HZ * `STL_TICK_S
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] axi_awaddr,
    input wire logic axi_awvalid,
    output logic axi_awready,
    input wire logic [31:0] axi_wdata,
    input wire logic [3:0] axi_wstrb,
    input wire logic axi_wvalid,
    output logic axi_wready,
    output logic [1:0] axi_bresp,
    output logic axi_bvalid,
    input wire logic axi_bready,
    input wire logic [7:0] axi_araddr,
    input wire logic axi_arvalid,
    output logic axi_arready,
    output logic [31:0] axi_rdata,
    output logic [1:0] axi_rresp,
    output logic axi_rvalid,
    input wire logic axi_rready,
    input wire logic sample_valid,
    input wire logic [15:0] temp_value,
    input wire logic [15:0] hum_value,
    input wire logic [1:0] ext_thr_valid,
    input wire logic [15:0] ext_thr_data,
    output logic [1:0] lim_state,
    output stl_pkg::stl_lim_tx_t lim_tx,
    output stl_pkg::stl_meas_tx_t meas_tx
);
    // ----------------------------------------
    // helper functions
    // ----------------------------------------
    // delay code to seconds: none,1,3,5,10,15,30 s,1,3,5,10,15,30,60 min
    function automatic logic [11:0] dly_sec(input logic [3:0] code);
        logic [11:0] s;
        s = 12'h000;
        unique case (code)
            4'h0: s = 12'h000;
            4'h1: s = 12'h001;
            4'h2: s = 12'h003;
            4'h3: s = 12'h005;
            4'h4: s = 12'h00A;
            4'h5: s = 12'h00F;
            4'h6: s = 12'h01E;
            4'h7: s = 12'h03C;
            4'h8: s = 12'h0B4;
            4'h9: s = 12'h12C;
            4'hA: s = 12'h258;
            4'hB: s = 12'h384;
            4'hC: s = 12'h708;
            default: s = 12'hE10;
        endcase
        return s;
    endfunction
    // hysteresis code to tenths; channel 0 in kelvin, channel 1 in percent
    function automatic logic signed [17:0] hyst_tenths(input logic ch, input logic [3:0] code);
        logic signed [17:0] h;
        h = 18'sh00000;
        if (ch)
        begin
            unique case (code[1:0])
                2'h0: h = 18'sh00000;
                2'h1: h = 18'sh00064;
                2'h2: h = 18'sh00096;
                default: h = 18'sh000C8;
            endcase
        end
        else if (code <= 4'h5)
            h = 18'(code) * 18'sh0000A;
        else if (code == 4'h6)
            h = 18'sh00064;
        else if (code == 4'h7)
            h = 18'sh00096;
        else
            h = 18'sh000C8;
        return h;
    endfunction
    // hold a threshold inside its channel's range
    function automatic logic signed [17:0] clamp_thr(input logic ch, input logic signed [17:0] v);
        logic signed [17:0] lo;
        logic signed [17:0] hi;
        lo = ch ? `STL_HUM_MIN : `STL_TEMP_MIN;
        hi = ch ? `STL_HUM_MAX : `STL_TEMP_MAX;
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction
    // byte-lane merge of a write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
            if (strb[b])
                r[b*8 +: 8] = nw[b*8 +: 8];
        return r;
    endfunction
    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic aw_hold_ff, w_hold_ff;
    logic [7:0] aw_addr_ff;
    logic [31:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;
    logic [31:0] ctrl_ff;
    logic [31:0] cfg_ff [2];
    logic [15:0] thr_ff [2];
    wire aw_take = axi_awvalid & awready_ff;
    wire w_take = axi_wvalid & wready_ff;
    wire do_write = aw_hold_ff & w_hold_ff & ~bvalid_ff;
    wire nxt_aw_hold = (aw_hold_ff | aw_take) & ~do_write;
    wire nxt_w_hold = (w_hold_ff | w_take) & ~do_write;
    wire nxt_bvalid = do_write | (bvalid_ff & ~axi_bready);
    wire ar_take = axi_arvalid & arready_ff;
    wire nxt_rvalid = ar_take | (rvalid_ff & ~axi_rready);
    // write decode
    wire wr_ctrl = do_write & (aw_addr_ff == `STL_OFS_CTRL);
    wire [1:0] wr_cfg = {do_write & (aw_addr_ff == `STL_OFS_CH1_CFG),
                         do_write & (aw_addr_ff == `STL_OFS_CH0_CFG)};
    wire [1:0] wr_thr = {do_write & (aw_addr_ff == `STL_OFS_CH1_THR),
                         do_write & (aw_addr_ff == `STL_OFS_CH0_THR)};
    wire wr_hit = wr_ctrl | (|wr_cfg) | (|wr_thr);
    wire [31:0] thr_mrg0 = merge({16'h0000, thr_ff[0]}, w_data_ff, w_strb_ff);
    wire [31:0] thr_mrg1 = merge({16'h0000, thr_ff[1]}, w_data_ff, w_strb_ff);
    wire signed [17:0] thr_cl0 = clamp_thr(1'b0, 18'(signed'(thr_mrg0[15:0])));
    wire signed [17:0] thr_cl1 = clamp_thr(1'b1, 18'(signed'(thr_mrg1[15:0])));
    // handshake state; a new address waits until the answer has gone
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
        end
        else
        begin
            aw_hold_ff <= nxt_aw_hold;
            w_hold_ff <= nxt_w_hold;
            awready_ff <= ~nxt_aw_hold & ~nxt_bvalid;
            wready_ff <= ~nxt_w_hold & ~nxt_bvalid;
            bvalid_ff <= nxt_bvalid;
            arready_ff <= ~nxt_rvalid;
            rvalid_ff <= nxt_rvalid;
        end
    end
    // payload capture, answers and configuration storage
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            aw_addr_ff <= 8'h00;
            w_data_ff <= 32'h0000_0000;
            w_strb_ff <= 4'h0;
            bresp_ff <= `STL_RESP_OKAY;
            ctrl_ff <= `STL_CTRL_RST;
            cfg_ff[0] <= `STL_CFG_RST;
            cfg_ff[1] <= `STL_CFG_RST;
            thr_ff[0] <= `STL_THR0_RST;
            thr_ff[1] <= `STL_THR1_RST;
        end
        else
        begin
            if (aw_take)
                aw_addr_ff <= {axi_awaddr[7:2], 2'h0};
            if (w_take)
            begin
                w_data_ff <= axi_wdata;
                w_strb_ff <= axi_wstrb;
            end
            if (do_write)
                bresp_ff <= wr_hit ? `STL_RESP_OKAY : `STL_RESP_SLVERR;
            if (wr_ctrl)
                ctrl_ff <= merge(ctrl_ff, w_data_ff, w_strb_ff) & `STL_CTRL_MASK;
            for (int c = 0; c < 2; c++)
                if (wr_cfg[c])
                    cfg_ff[c] <= merge(cfg_ff[c], w_data_ff, w_strb_ff) & `STL_CFG_MASK;
            if (wr_thr[0])
                thr_ff[0] <= thr_cl0[15:0];
            if (wr_thr[1])
                thr_ff[1] <= thr_cl1[15:0];
        end
    end
    // ----------------------------------------
    // shared decode and one-second tick
    // ----------------------------------------
    stl_pkg::stl_ctrl_t ctrl;
    assign ctrl = stl_pkg::stl_ctrl_t'(ctrl_ff);
    logic [31:0] tick_cnt_ff;
    logic tick_ff;
    wire [1:0] ch_en = {ctrl.hum_en & (ctrl.hum_lim == `STL_LIM_BOTH),
                        ctrl.temp_en & (ctrl.temp_lim != 2'h0)};
    wire tick_wrap = (tick_cnt_ff == TICK_CYCLES - 1);
    // prescaler, the only time base of every timer
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            tick_cnt_ff <= 32'h0000_0000;
            tick_ff <= 1'b0;
        end
        else
        begin
            tick_cnt_ff <= tick_wrap ? 32'h0000_0000 : tick_cnt_ff + 32'h0000_0001;
            tick_ff <= tick_wrap;
        end
    end
    // ----------------------------------------
    // limit channels: 0 temperature, 1 humidity
    // ----------------------------------------
    logic [1:0] obj_v, raw_v, run_v, txv_v, txd_v;
    logic signed [15:0] act_thr_v [2];
    for (genvar c = 0; c < 2; c++)
    begin : g_ch
        stl_pkg::stl_ch_cfg_t cfg;
        logic cond_ff, obj_ff, tx_ff, txd_ff, ext_seen_ff;
        logic [15:0] ext_thr_ff;
        logic [11:0] dly_cnt_ff;
        logic [10:0] cyc_cnt_ff;
        assign cfg = stl_pkg::stl_ch_cfg_t'(cfg_ff[c]);
        wire signed [17:0] meas = 18'(signed'(c ? hum_value : temp_value));
        // received value: two bytes in tenths, one byte in whole units
        wire signed [17:0] ext_word = 18'(signed'(ext_thr_data));
        wire signed [17:0] ext_byte = c ? 18'(ext_thr_data[7:0]) * 18'sh0000A
                                        : 18'(signed'(ext_thr_data[7:0])) * 18'sh0000A;
        wire signed [17:0] ext_cl = clamp_thr(1'(c),
                                              (cfg.ext_src == 2'h2) ? ext_byte : ext_word);
        wire use_ext = (cfg.ext_src != 2'h0) & ext_seen_ff;
        wire signed [17:0] thr = 18'(signed'(use_ext ? ext_thr_ff : thr_ff[c]));
        wire signed [17:0] hyst = hyst_tenths(1'(c), cfg.hyst);
        wire falling = cfg.mode[1]; // set on undershoot
        wire set_lvl = ~cfg.mode[0]; // level while the set condition holds
        wire [1:0] grp = cfg.mode[3:2]; // 1 clear side silent, 2 set side silent
        wire set_hit = falling ? (meas < thr) : (meas > thr);
        wire clr_hit = falling ? (meas > thr + hyst) : (meas < thr - hyst);
        wire raw = cond_ff ? set_lvl : ~set_lvl;
        wire silent = ((grp == 2'h1) & ~cond_ff) | ((grp == 2'h2) & cond_ff);
        wire [11:0] dsec = dly_sec(raw ? cfg.on_dly : cfg.off_dly);
        wire accept = (raw != obj_ff) & (dly_cnt_ff >= dsec);
        wire [10:0] cyc_lim = 11'(cfg.cycle) * `STL_CYC_UNIT_S;
        wire cyc_due = tick_ff & (cfg.cycle != 7'h00) & (cyc_cnt_ff + 11'h001 >= cyc_lim);
        wire send = ((accept & cfg.soc) | cyc_due) & ~silent;
        // hysteresis state, moved only by a new sample, held clear while the channel is off
        always_ff @(posedge core_clk)
        begin
            if (rst | ~ch_en[c])
                cond_ff <= 1'b0;
            else if (sample_valid & set_hit)
                cond_ff <= 1'b1;
            else if (sample_valid & clr_hit)
                cond_ff <= 1'b0;
        end
        // received threshold; the configured one stands until the first arrives
        always_ff @(posedge core_clk)
        begin
            if (rst)
            begin
                ext_thr_ff <= 16'h0000;
                ext_seen_ff <= 1'b0;
            end
            else if (ext_thr_valid[c] & (cfg.ext_src != 2'h0))
            begin
                ext_thr_ff <= ext_cl[15:0];
                ext_seen_ff <= 1'b1;
            end
        end
        // delay timer restarts whenever the raw level returns to the object
        always_ff @(posedge core_clk)
        begin
            if (rst | ~ch_en[c] | (raw == obj_ff))
                dly_cnt_ff <= 12'h000;
            else if (tick_ff & (dly_cnt_ff < dsec))
                dly_cnt_ff <= dly_cnt_ff + 12'h001;
        end
        // accepted object, cycle counter and telegram requests
        always_ff @(posedge core_clk)
        begin
            if (rst | ~ch_en[c])
            begin
                obj_ff <= 1'b0;
                cyc_cnt_ff <= 11'h000;
                tx_ff <= 1'b0;
                txd_ff <= 1'b0;
            end
            else
            begin
                if (accept)
                    obj_ff <= raw;
                if (cfg.cycle == 7'h00)
                    cyc_cnt_ff <= 11'h000;
                else if (tick_ff)
                    cyc_cnt_ff <= cyc_due ? 11'h000 : cyc_cnt_ff + 11'h001;
                tx_ff <= send;
                txd_ff <= accept ? raw : obj_ff;
            end
        end
        assign obj_v[c] = obj_ff;
        assign raw_v[c] = raw;
        assign run_v[c] = raw != obj_ff;
        assign txv_v[c] = tx_ff;
        assign txd_v[c] = txd_ff;
        assign act_thr_v[c] = thr[15:0];
    end
    // ----------------------------------------
    // temperature measured-value sending
    // ----------------------------------------
    logic signed [15:0] ref_ff;
    logic pend_ff, mtx_ff;
    logic [3:0] pend_cnt_ff;
    logic [10:0] mcyc_cnt_ff;
    logic [15:0] mval_ff;
    wire signed [17:0] mdiff = 18'(signed'(temp_value)) - 18'(ref_ff);
    wire [17:0] mabs = mdiff[17] ? 18'(-mdiff) : 18'(mdiff);
    // step of 60 degrees: 0.3, 0.6, 1.8, 6.0 in tenths
    wire [17:0] mstep = (ctrl.step == 2'h0) ? 18'h00003 : (ctrl.step == 2'h1) ? 18'h00006 :
                        (ctrl.step == 2'h2) ? 18'h00012 : 18'h0003C;
    wire start_pend = sample_valid & ~pend_ff & (mabs >= mstep);
    wire pend_done = pend_ff & tick_ff & (pend_cnt_ff + 4'h1 >= `STL_MEAS_DLY_S);
    wire [10:0] mcyc_lim = 11'(ctrl.meas_cycle) * `STL_CYC_UNIT_S;
    wire mcyc_due = tick_ff & (ctrl.meas_cycle != 7'h00) & (mcyc_cnt_ff + 11'h001 >= mcyc_lim);
    // change path and cyclic path share only the output strobe
    always_ff @(posedge core_clk)
    begin
        if (rst | ~ctrl.temp_en)
        begin
            ref_ff <= 16'h0000;
            pend_ff <= 1'b0;
            pend_cnt_ff <= 4'h0;
            mcyc_cnt_ff <= 11'h000;
            mtx_ff <= 1'b0;
            mval_ff <= 16'h0000;
        end
        else
        begin
            if (start_pend)
            begin
                pend_ff <= 1'b1;
                pend_cnt_ff <= 4'h0;
            end
            else if (pend_done)
            begin
                pend_ff <= 1'b0;
                ref_ff <= temp_value;
            end
            else if (pend_ff & tick_ff)
                pend_cnt_ff <= pend_cnt_ff + 4'h1;
            if (ctrl.meas_cycle == 7'h00)
                mcyc_cnt_ff <= 11'h000;
            else if (tick_ff)
                mcyc_cnt_ff <= mcyc_due ? 11'h000 : mcyc_cnt_ff + 11'h001;
            mtx_ff <= pend_done | mcyc_due;
            mval_ff <= temp_value;
        end
    end
    // ----------------------------------------
    // read side
    // ----------------------------------------
    wire [31:0] status_word = {24'h000000, run_v, raw_v, 2'h0, obj_v};
    wire rd_ok = (axi_araddr[7:2] <= 6'h06);
    wire [31:0] rd_word = (axi_araddr[7:2] == 6'h00) ? ctrl_ff :
                          (axi_araddr[7:2] == 6'h01) ? cfg_ff[0] :
                          (axi_araddr[7:2] == 6'h02) ? {16'h0000, act_thr_v[0]} :
                          (axi_araddr[7:2] == 6'h03) ? cfg_ff[1] :
                          (axi_araddr[7:2] == 6'h04) ? {16'h0000, act_thr_v[1]} :
                          (axi_araddr[7:2] == 6'h05) ? status_word :
                          (axi_araddr[7:2] == 6'h06) ? {16'h0000, mval_ff} : 32'h0000_0000;
    // read answer latched at the address handshake
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `STL_RESP_OKAY;
        end
        else if (ar_take)
        begin
            rdata_ff <= rd_word;
            rresp_ff <= rd_ok ? `STL_RESP_OKAY : `STL_RESP_SLVERR;
        end
    end
    // ----------------------------------------
    // outputs, all straight from flops
    // ----------------------------------------
    assign axi_awready = awready_ff;
    assign axi_wready = wready_ff;
    assign axi_bvalid = bvalid_ff;
    assign axi_bresp = bresp_ff;
    assign axi_arready = arready_ff;
    assign axi_rvalid = rvalid_ff;
    assign axi_rdata = rdata_ff;
    assign axi_rresp = rresp_ff;
    assign lim_state = obj_v;
    assign lim_tx = '{valid: txv_v, value: txd_v};
    assign meas_tx = '{valid: mtx_ff, value: mval_ff};
endmodule
`default_nettype wire

// [verilog/stl_consts.svh]
// named constants of the threshold and telegram block
// assumes a 40 MHz core clock and register words on AXI4-Lite
`ifndef STL_CONSTS_SVH
`define STL_CONSTS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define STL_OFS_CTRL 8'h00
`define STL_OFS_CH0_CFG 8'h04
`define STL_OFS_CH0_THR 8'h08
`define STL_OFS_CH1_CFG 8'h0C
`define STL_OFS_CH1_THR 8'h10
`define STL_OFS_STATUS 8'h14
`define STL_OFS_MEAS 8'h18
// ----------------------------------------
// reset values, answers and write masks
// ----------------------------------------
`define STL_CTRL_RST 32'h0000_0000
`define STL_CFG_RST 32'h0000_0000
`define STL_THR0_RST 16'h00C8
`define STL_THR1_RST 16'h01F4
`define STL_RESP_OKAY 2'h0
`define STL_RESP_SLVERR 2'h2
`define STL_CTRL_MASK 32'h0000_7FFF
`define STL_CFG_MASK 32'h03FF_FFFF
// ----------------------------------------
// timing
// ----------------------------------------
`define STL_CLK_HZ 40000000
`define STL_TICK_S 1
`define STL_CYC_UNIT_S 11'h00A
`define STL_MEAS_DLY_S 4'hA
// ----------------------------------------
// value limits in tenths of a unit, and the both-limits code
// ----------------------------------------
`define STL_HUM_MIN 18'sh000C8
`define STL_HUM_MAX 18'sh00384
`define STL_TEMP_MIN (-18'sh00096)
`define STL_TEMP_MAX 18'sh001F4
`define STL_LIM_BOTH 2'h2
`endif

// [verilog/stl_pkg.sv]
// types of the threshold and telegram block
// assumes stl_consts.svh for every number
package stl_pkg;
    // ----------------------------------------
    // limit channel configuration word
    // ----------------------------------------
    typedef struct packed {
        logic [5:0] rsv;
        logic [1:0] ext_src; // 0 config, 1 two-byte, 2 one-byte
        logic [6:0] cycle; // times ten seconds
        logic soc; // send on change
        logic [3:0] off_dly;
        logic [3:0] on_dly;
        logic [3:0] hyst;
        logic [3:0] mode; // activation variant 0..11
    } stl_ch_cfg_t;
    // ----------------------------------------
    // general control word
    // ----------------------------------------
    typedef struct packed {
        logic [16:0] rsv;
        logic [6:0] meas_cycle;
        logic [1:0] step;
        logic [1:0] hum_lim;
        logic [1:0] temp_lim;
        logic hum_en;
        logic temp_en;
    } stl_ctrl_t;
    // ----------------------------------------
    // telegram requests toward the building bus
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] valid; // one-cycle pulse per limit channel
        logic [1:0] value;
    } stl_lim_tx_t;
    typedef struct packed {
        logic valid; // one-cycle pulse
        logic [15:0] value;
    } stl_meas_tx_t;
endpackage

// [testbench/stl_top_monitor.sv]
// checker of handshakes and limit telegrams at the block ports
// assumes it is bound onto stl_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module stl_chk (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic axi_awready,
    input wire logic axi_wready,
    input wire logic axi_bvalid,
    input wire logic axi_bready,
    input wire logic axi_arvalid,
    input wire logic axi_arready,
    input wire logic axi_rvalid,
    input wire logic axi_rready,
    input wire logic [1:0] lim_state,
    input wire stl_pkg::stl_lim_tx_t lim_tx,
    input wire stl_pkg::stl_meas_tx_t meas_tx
);
    // single domain, so clock and reset stated once
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_rd_answer: assert property (axi_arvalid && axi_arready |=> axi_rvalid && !axi_arready)
        else $error("read answer late");
    a_rd_hold: assert property (axi_rvalid && !axi_rready |=> axi_rvalid)
        else $error("read answer dropped");
    a_wr_hold: assert property (axi_bvalid && !axi_bready |=> axi_bvalid)
        else $error("write answer dropped");
    a_wr_busy: assert property (axi_bvalid |-> !axi_awready && !axi_wready)
        else $error("write taken while busy");
    a_lim_pulse: assert property (lim_tx.valid[0] |=> !lim_tx.valid[0])
        else $error("limit pulse too long");
    a_lim_value: assert property (lim_tx.valid[0] |-> lim_tx.value[0] == lim_state[0])
        else $error("limit telegram differs from object");
    a_meas_gap: assert property (meas_tx.valid |=> !meas_tx.valid [*2])
        else $error("measurement pulse too long");
    a_reset_quiet: assert property ($fell(rst) |-> lim_state == 2'h0 && !meas_tx.valid)
        else $error("outputs not cleared by reset");
    c_lim: cover property (lim_tx.valid[0]);
    c_meas: cover property (meas_tx.valid);
    c_rd: cover property (axi_rvalid && axi_rready);
endmodule
bind stl_top stl_chk chk_u (.*);
`default_nettype wire

// [testbench/stl_bus_rx.sv]
// building bus side model: counts limit telegrams of channel one
// assumes every request is taken at once, the bus has no back-pressure
`timescale 1ns/1ps
`default_nettype none
module stl_bus_rx (
    input wire logic core_clk,
    input wire stl_pkg::stl_lim_tx_t lim_tx,
    output logic [7:0] lim_cnt
);
    // count from time zero, the block holds its pulses low in reset
    initial lim_cnt = 8'h00;
    always @(posedge core_clk)
        if (lim_tx.valid[0] === 1'b1) lim_cnt <= lim_cnt + 8'h01;
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench of the threshold and telegram block
// assumes stl_top, stl_bus_rx and the bound checker; tick shortened to 10 cycles
`timescale 1ns/1ps
`default_nettype none
`include "stl_consts.svh"
module testbench;
    logic core_clk = 1'b0, rst = 1'b1, sample_valid = 1'b0;
    logic axi_awvalid = 1'b0, axi_wvalid = 1'b0, axi_bready = 1'b0;
    logic axi_arvalid = 1'b0, axi_rready = 1'b0;
    logic axi_awready, axi_wready, axi_bvalid, axi_arready, axi_rvalid;
    logic [7:0] axi_awaddr = 8'h00, axi_araddr = 8'h00, lim_cnt, cnt0;
    logic [31:0] axi_wdata = 32'h0, axi_rdata, lfsr = 32'h0001_4C11;
    logic [1:0] axi_bresp, axi_rresp, lim_state, ext_thr_valid = 2'h0;
    logic [15:0] temp_value = 16'h0, hum_value = 16'h0, t1, ext_thr_data = 16'h0;
    stl_pkg::stl_lim_tx_t lim_tx;
    stl_pkg::stl_meas_tx_t meas_tx;
    int fails = 0, samples_checked = 0;
    logic exp_lim[$];
    logic [15:0] exp_meas[$];
    stl_top #(.TICK_CYCLES(10)) dut_u (.axi_wstrb(4'hF), .*);
    stl_bus_rx bus_u (.core_clk(core_clk), .lim_tx(lim_tx), .lim_cnt(lim_cnt));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task chk(input logic [33:0] got, input logic [33:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task end_of_test;
        if (exp_lim.size() != 0 || exp_meas.size() != 0) fails++;
        $display("checks %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // each channel released at the edge that takes it
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        axi_awaddr <= a;
        axi_wdata <= d;
        axi_awvalid <= 1'b1;
        axi_wvalid <= 1'b1;
        axi_bready <= 1'b1;
        do
        begin
            @(posedge core_clk);
            if (axi_awready) axi_awvalid <= 1'b0;
            if (axi_wready) axi_wvalid <= 1'b0;
        end
        while (axi_bvalid !== 1'b1);
        axi_bready <= 1'b0;
        chk(34'(axi_bresp), 34'(r));
    endtask
    task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        axi_araddr <= a;
        axi_arvalid <= 1'b1;
        axi_rready <= 1'b1;
        do
        begin
            @(posedge core_clk);
            if (axi_arready) axi_arvalid <= 1'b0;
        end
        while (axi_rvalid !== 1'b1);
        axi_rready <= 1'b0;
        chk({axi_rresp, axi_rdata}, {r, d});
    endtask
    // random humidity and received thresholds ride along; source 0 must ignore them
    task smp(input logic [15:0] t);
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        temp_value <= t;
        hum_value <= lfsr[15:0];
        ext_thr_data <= lfsr[31:16];
        ext_thr_valid <= lfsr[1:0];
        sample_valid <= 1'b1;
        @(posedge core_clk);
        sample_valid <= 1'b0;
        ext_thr_valid <= 2'h0;
        repeat (3) @(posedge core_clk);
    endtask
    // ----------------------------------------
    // clock, watchers, watchdog
    // ----------------------------------------
    initial forever #12.5 core_clk = ~core_clk;
    // an empty queue yields x, so a stray telegram always mismatches
    always @(posedge core_clk)
    begin
        if (lim_tx.valid[0] === 1'b1)
            chk(34'(lim_tx.value[0]), 34'(exp_lim.size() ? exp_lim.pop_front() : 1'bx));
        if (meas_tx.valid === 1'b1)
            chk(34'(meas_tx.value), 34'(exp_meas.size() ? exp_meas.pop_front() : 16'hXXXX));
    end
    initial
    begin
        repeat (5000) @(posedge core_clk);
        fails++;
        end_of_test();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        wr(`STL_OFS_CTRL, 32'h0000_00C5, `STL_RESP_OKAY);
        wr(`STL_OFS_CH0_CFG, 32'h0001_0000, `STL_RESP_OKAY);
        wr(`STL_OFS_STATUS, 32'h0000_0003, `STL_RESP_SLVERR);
        rd(8'h1C, 32'h0, `STL_RESP_SLVERR);
        rd(`STL_OFS_CTRL, 32'h0000_00C5, `STL_RESP_OKAY);
        wr(`STL_OFS_CH0_THR, 32'h0000_7FFF, `STL_RESP_OKAY);
        rd(`STL_OFS_CH0_THR, 32'h0000_01F4, `STL_RESP_OKAY);
        wr(`STL_OFS_CH0_THR, 32'h0000_00C8, `STL_RESP_OKAY);
        t1 = 16'h00C9 + 16'(lfsr[4:0]);
        exp_lim.push_back(1'b1);
        exp_meas.push_back(t1);
        smp(t1);
        repeat (130) @(posedge core_clk);
        smp(16'h00C8);
        exp_lim.push_back(1'b0);
        smp(16'h00C7);
        wr(`STL_OFS_CH0_CFG, 32'h0001_0200, `STL_RESP_OKAY);
        exp_lim.push_back(1'b1);
        smp(t1 + 16'h0005);
        repeat (8) @(posedge core_clk);
        chk(34'(lim_state), 34'h0);
        repeat (40) @(posedge core_clk);
        chk(34'(lim_state), 34'h1);
        wr(`STL_OFS_CH0_CFG, 32'h0000_0000, `STL_RESP_OKAY);
        cnt0 = lim_cnt;
        smp(16'h00C7);
        repeat (150) @(posedge core_clk);
        chk(34'(lim_state), 34'h0);
        chk(34'(lim_cnt), 34'(cnt0));
        end_of_test();
    end
endmodule
`default_nettype wire
